// file: cis_core.sv
// Purpose: Executes stores, program loads, I/O, stack, shift and flag ops.
// Assumes: Command, memory and register ports are all on mclk.
// Notes: Register file, I/O space and internal RAM live inside this block.
// What this block does
// - Displaced store via Y or Z, one cycle
// - Store at Z, then Z plus one
// - Decrement Z, then store at new Z
// - Program load into R0 or Rd, three cycles
// - I/O in and out, one cycle, flags kept
// - Push one cycle, pop two, flags kept
// - Left shifts: carry from bit 7, flags
// - Right shifts: carry from bit 0, flags
// - Set or clear one I/O bit
// - Bit to transfer flag and back
// - Set or clear any single status flag
// - Break, nop, sleep, watchdog: one cycle
// - Controller-routed stores add extra wait cycles
`timescale 1ns/1ps
`default_nettype none
module cis_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Command port
    input wire logic cmd_valid,
    input wire cis_pkg::cis_op_t cmd_op,
    input wire logic [4:0] cmd_rd,
    input wire logic [4:0] cmd_rr,
    input wire logic [2:0] cmd_bit,
    input wire logic [5:0] cmd_q,
    input wire logic cmd_use_y,
    input wire logic [5:0] cmd_io,
    output logic cmd_ready,
    output logic cmd_done,
    // Program memory port
    output logic pm_req,
    output logic [15:0] pm_addr,
    input wire logic [7:0] pm_rdata,
    // Memory controller port
    output logic nvm_req,
    output logic [15:0] nvm_addr,
    output logic [7:0] nvm_wdata,
    input wire logic nvm_ack,
    // Control pulses and status flags to other units
    output logic brk_pulse,
    output logic sleep_pulse,
    output logic wdr_pulse,
    output logic [7:0] status_register,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    import cis_pkg::*;

    logic [7:0] rf [RF_N];
    logic [7:0] io [IO_N];
    logic [7:0] ram [RAM_N];
    logic [15:0] sp_r;
    cis_state_t st_r;
    logic [1:0] cnt_r;
    logic first_r;
    logic lpm_r;
    logic [4:0] dst_r;
    logic [7:0] status_register_nxt;
    logic [7:0] sh_res;
    logic sh_c;

    // Operand fetch and pointers
    wire take = cmd_valid && cmd_ready;
    wire [7:0] rd_v = rf[cmd_rd];
    wire [7:0] rr_v = rf[cmd_rr];
    wire [15:0] y_ptr = {rf[R_YH], rf[R_YL]};
    wire [15:0] z_ptr = {rf[R_ZH], rf[R_ZL]};
    wire [15:0] z_inc = z_ptr + 16'h0001;
    wire [15:0] z_dec = z_ptr - 16'h0001;
    wire [15:0] disp_base = cmd_use_y ? y_ptr : z_ptr;

    // Store address decode; pre-decrement uses the new Z
    wire is_std = cmd_op == OP_STD;
    wire is_stzi = cmd_op == OP_STZI;
    wire is_stzd = cmd_op == OP_STZD;
    wire is_store = is_std || is_stzi || is_stzd;
    wire [15:0] st_addr = is_std ? disp_base + {10'h000, cmd_q} :
                          is_stzd ? z_dec : z_ptr;
    wire [15:0] st_off = st_addr - RAM_BASE;
    wire st_int = st_off[15:RAM_AW] == '0;
    wire st_ext = take && is_store && !st_int;

    // Multi-cycle classes
    wire is_lpm = cmd_op == OP_LPM0 || cmd_op == OP_LPM || cmd_op == OP_LPMI;
    wire is_pop = cmd_op == OP_POP;
    wire z_post = is_stzi || cmd_op == OP_LPMI;

    // Stack offsets into internal RAM; wraps inside the window
    wire [15:0] sp_inc = sp_r + 16'h0001;
    wire [15:0] sp_dec = sp_r - 16'h0001;
    wire [15:0] sp_off = sp_r - RAM_BASE;

    // Register port decode
    wire a_rf = reg_addr < A_IO_BASE;
    wire a_io = reg_addr >= A_IO_BASE && reg_addr <= A_IO_END;
    wire [7:0] a_io_off = reg_addr - A_IO_BASE;
    wire w_rf = reg_wr && a_rf;
    wire w_io = reg_wr && a_io;
    wire w_status_register = reg_wr && reg_addr == A_STATUS_REGISTER;
    wire w_spl = reg_wr && reg_addr == A_SPL;
    wire w_sph = reg_wr && reg_addr == A_SPH;
    wire [7:0] stat_v = {6'h00, st_r != ST_IDLE, nvm_req};
    wire [7:0] bus_rmux = a_rf ? rf[reg_addr[4:0]] :
                          a_io ? io[a_io_off[5:0]] :
                          reg_addr == A_STATUS_REGISTER ? status_register :
                          reg_addr == A_SPL ? sp_r[7:0] :
                          reg_addr == A_SPH ? sp_r[15:8] :
                          reg_addr == A_STAT ? stat_v : 8'h00;

    // Shifter; left forms take carry from bit 7, right from bit 0
    always_comb begin
        sh_res = rd_v;
        sh_c = rd_v[0];
        unique case (cmd_op)
            OP_LSL: begin
                sh_res = {rd_v[6:0], 1'b0};
                sh_c = rd_v[7];
            end
            OP_ROL: begin
                sh_res = {rd_v[6:0], status_register[F_C]};
                sh_c = rd_v[7];
            end
            OP_LSR: sh_res = {1'b0, rd_v[7:1]};
            OP_ROR: sh_res = {status_register[F_C], rd_v[7:1]};
            OP_ASR: sh_res = {rd_v[7], rd_v[7:1]};
            default: sh_res = rd_v;
        endcase
    end

    // Flag update; every op not listed keeps the status register as is
    always_comb begin
        status_register_nxt = status_register;
        if (take) begin
            unique case (cmd_op)
                OP_LSL, OP_ROL, OP_LSR, OP_ROR, OP_ASR: begin
                    status_register_nxt[F_C] = sh_c;
                    status_register_nxt[F_Z] = sh_res == 8'h00;
                    status_register_nxt[F_N] = sh_res[7];
                    status_register_nxt[F_V] = sh_res[7] ^ sh_c;
                    if (cmd_op == OP_LSL || cmd_op == OP_ROL) begin
                        status_register_nxt[F_H] = rd_v[3];
                    end
                end
                OP_BST: status_register_nxt[F_T] = rr_v[cmd_bit];
                OP_BSET: status_register_nxt[cmd_bit] = 1'b1;
                OP_BCLR: status_register_nxt[cmd_bit] = 1'b0;
                default: status_register_nxt = status_register;
            endcase
        end
    end

    // Status register; any command taken in the same cycle wins over the port, even one that keeps the flags
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            status_register <= STATUS_REGISTER_RST;
        end else if (take || !w_status_register) begin
            status_register <= status_register_nxt;
        end else begin
            status_register <= reg_wdata;
        end
    end

    // Sequencer: holds ready low for the extra cycles of slow instructions
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= ST_IDLE;
            cnt_r <= 2'h0;
            first_r <= 1'b0;
            lpm_r <= 1'b0;
            dst_r <= 5'h00;
            cmd_ready <= 1'b1;
            cmd_done <= 1'b0;
            pm_req <= 1'b0;
            pm_addr <= 16'h0000;
            nvm_req <= 1'b0;
            nvm_addr <= 16'h0000;
            nvm_wdata <= 8'h00;
        end else begin
            cmd_done <= 1'b0;
            pm_req <= 1'b0;
            first_r <= 1'b0;
            unique case (st_r)
                ST_IDLE: begin
                    if (take) begin
                        dst_r <= cmd_op == OP_LPM0 ? R_ZERO : cmd_rd;
                        lpm_r <= is_lpm;
                        if (is_lpm || is_pop) begin
                            st_r <= ST_MULTI;
                            first_r <= 1'b1;
                            cmd_ready <= 1'b0;
                            cnt_r <= (is_lpm ? CYC_LPM : CYC_POP) - 2'h1;
                            pm_req <= is_lpm;
                            pm_addr <= z_ptr;
                        end else if (st_ext) begin
                            // Controller path: at least one wait cycle for the ack
                            st_r <= ST_NVM;
                            cmd_ready <= 1'b0;
                            nvm_req <= 1'b1;
                            nvm_addr <= st_addr;
                            nvm_wdata <= rr_v;
                        end else begin
                            cmd_done <= 1'b1;
                        end
                    end
                end
                ST_MULTI: begin
                    cnt_r <= cnt_r - 2'h1;
                    if (cnt_r == 2'h1) begin
                        st_r <= ST_IDLE;
                        cmd_ready <= 1'b1;
                        cmd_done <= 1'b1;
                    end
                end
                ST_NVM: begin
                    if (nvm_ack) begin
                        st_r <= ST_IDLE;
                        nvm_req <= 1'b0;
                        cmd_ready <= 1'b1;
                        cmd_done <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Control pulses, one cycle after the instruction is taken
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            brk_pulse <= 1'b0;
            sleep_pulse <= 1'b0;
            wdr_pulse <= 1'b0;
        end else begin
            brk_pulse <= take && cmd_op == OP_BRK;
            sleep_pulse <= take && cmd_op == OP_SLP;
            wdr_pulse <= take && cmd_op == OP_WDR;
        end
    end

    // Stack pointer; pop moves it first so the read sees the new top
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_r <= SP_RST;
        end else if (take && cmd_op == OP_PUSH) begin
            sp_r <= sp_dec;
        end else if (take && is_pop) begin
            sp_r <= sp_inc;
        end else if (w_spl) begin
            sp_r[7:0] <= reg_wdata;
        end else if (w_sph) begin
            sp_r[15:8] <= reg_wdata;
        end
    end

    // Internal RAM: single-cycle stores and pushes
    always_ff @(posedge mclk) begin
        if (take && is_store && st_int) begin
            ram[st_off[RAM_AW-1:0]] <= rr_v;
        end else if (take && cmd_op == OP_PUSH) begin
            ram[sp_off[RAM_AW-1:0]] <= rr_v;
        end
    end

    // I/O space; core access wins over the register port
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < IO_N; i++) begin
                io[i] <= 8'h00;
            end
        end else if (take && cmd_op == OP_OUT) begin
            io[cmd_io] <= rr_v;
        end else if (take && cmd_op == OP_SBI) begin
            io[cmd_io][cmd_bit] <= 1'b1;
        end else if (take && cmd_op == OP_CBI) begin
            io[cmd_io][cmd_bit] <= 1'b0;
        end else if (w_io) begin
            io[a_io_off[5:0]] <= reg_wdata;
        end
    end

    // Register file; later writes in this process take priority
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < RF_N; i++) begin
                rf[i] <= 8'h00;
            end
        end else begin
            if (w_rf) begin
                rf[reg_addr[4:0]] <= reg_wdata;
            end
            if (take) begin
                unique case (cmd_op)
                    OP_IN: rf[cmd_rd] <= io[cmd_io];
                    OP_LSL, OP_ROL, OP_LSR, OP_ROR, OP_ASR: rf[cmd_rd] <= sh_res;
                    OP_SWAP: rf[cmd_rd] <= {rd_v[3:0], rd_v[7:4]};
                    OP_BLD: rf[cmd_rd][cmd_bit] <= status_register[F_T];
                    default: ;
                endcase
                if (z_post) begin
                    {rf[R_ZH], rf[R_ZL]} <= z_inc;
                end else if (is_stzd) begin
                    {rf[R_ZH], rf[R_ZL]} <= z_dec;
                end
            end
            if (st_r == ST_MULTI && first_r) begin
                rf[dst_r] <= lpm_r ? pm_rdata : ram[sp_off[RAM_AW-1:0]];
            end
        end
    end

    // Register port read data, valid the cycle after the strobe only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= bus_rmux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : cis_core
`default_nettype wire

// file: cis_core_assertions.sv
// Purpose: Port checks on command timing, pulses and status flags.
// Assumes: One clock domain, reset async and active high.
// Notes: Stores are left out of the latency checks because the controller may stall them.
`timescale 1ns/1ps
`default_nettype none
module cis_core_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Command port
    input wire logic cmd_valid,
    input wire cis_pkg::cis_op_t cmd_op,
    input wire logic [2:0] cmd_bit,
    input wire logic cmd_ready,
    input wire logic cmd_done,
    // Memory, pulses and status
    input wire logic pm_req,
    input wire logic nvm_req,
    input wire logic nvm_ack,
    input wire logic brk_pulse,
    input wire logic sleep_pulse,
    input wire logic wdr_pulse,
    input wire logic [7:0] status_register,
    input wire logic reg_wr
);
    import cis_pkg::*;
    // A taken command wins over a port write to the status register; flag checks still skip port writes
    wire logic tk = cmd_valid && cmd_ready;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    property p_one;
        tk && !(cmd_op inside {OP_LPM0, OP_LPM, OP_LPMI, OP_POP, OP_STD, OP_STZI, OP_STZD})
            |=> cmd_done && cmd_ready;
    endproperty
    a_one: assert property (p_one) else $error("one-cycle op late");
    property p_lpm;
        tk && cmd_op inside {OP_LPM0, OP_LPM, OP_LPMI}
            |=> pm_req && !cmd_ready ##1 !cmd_ready && !cmd_done ##1 cmd_ready && cmd_done;
    endproperty
    a_lpm: assert property (p_lpm) else $error("program load timing");
    property p_pop;
        tk && cmd_op == OP_POP |=> !cmd_ready && !cmd_done ##1 cmd_done;
    endproperty
    a_pop: assert property (p_pop) else $error("pop timing");
    property p_keep;
        tk && !reg_wr && !(cmd_op inside {OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_BST,
            OP_BSET, OP_BCLR}) |=> $stable(status_register);
    endproperty
    a_keep: assert property (p_keep) else $error("flags moved");
    property p_bst;
        tk && !reg_wr && cmd_op == OP_BST
            |=> (status_register & 8'hbf) == ($past(status_register) & 8'hbf);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store touched other flags");
    property p_bset;
        tk && !reg_wr && cmd_op == OP_BSET
            |=> status_register == ($past(status_register) | (8'h01 << $past(cmd_bit)));
    endproperty
    a_bset: assert property (p_bset) else $error("flag set wrong");
    property p_bclr;
        tk && !reg_wr && cmd_op == OP_BCLR
            |=> status_register == ($past(status_register) & ~(8'h01 << $past(cmd_bit)));
    endproperty
    a_bclr: assert property (p_bclr) else $error("flag clear wrong");
    property p_brk;
        tk && cmd_op == OP_BRK |=> brk_pulse ##1 !brk_pulse;
    endproperty
    a_brk: assert property (p_brk) else $error("break pulse wrong");
    property p_wdr;
        tk && cmd_op == OP_WDR |=> wdr_pulse ##1 !wdr_pulse;
    endproperty
    a_wdr: assert property (p_wdr) else $error("watchdog pulse wrong");
    property p_slp;
        tk && cmd_op == OP_SLP |=> sleep_pulse ##1 !sleep_pulse;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep pulse wrong");
    property p_nvm;
        nvm_req && nvm_ack |=> !nvm_req && cmd_done && cmd_ready;
    endproperty
    a_nvm: assert property (p_nvm) else $error("controller store end wrong");
    // Main scenarios reached
    c_lpm: cover property (tk && cmd_op == OP_LPMI);
    c_pop: cover property (tk && cmd_op == OP_POP);
    c_nvm: cover property (nvm_req && nvm_ack);
endmodule : cis_core_chk
bind cis_core cis_core_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_bit(cmd_bit), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .pm_req(pm_req), .nvm_req(nvm_req), .nvm_ack(nvm_ack), .brk_pulse(brk_pulse),
    .sleep_pulse(sleep_pulse),
    .wdr_pulse(wdr_pulse), .status_register(status_register), .reg_wr(reg_wr));
`default_nettype wire

// file: cis_core_tb.sv
// Purpose: Self-checking bench for the instruction execution unit.
// Assumes: Program memory answers at once from pm_addr; controller acks late.
// Notes: RAM has no port of its own, so stores are read back by popping them.
`timescale 1ns/1ps
`default_nettype none
module cis_core_tb;
    import cis_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    cis_op_t cmd_op = OP_NOP;
    logic [4:0] cmd_rd = 5'h00;
    logic [4:0] cmd_rr = 5'h00;
    logic [2:0] cmd_bit = 3'h0;
    logic [5:0] cmd_q = 6'h00;
    logic cmd_use_y = 1'b0;
    logic [5:0] cmd_io = 6'h00;
    logic nvm_ack = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic cmd_ready, cmd_done, pm_req, nvm_req, brk_pulse, sleep_pulse, wdr_pulse;
    wire logic [15:0] pm_addr, nvm_addr;
    wire logic [7:0] pm_rdata, nvm_wdata, status_register, reg_rdata;
    logic [1:0] ncnt = 2'h0;
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] sr, v, w;
    logic [15:0] e;
    logic [5:0] x;
    logic [2:0] b, c;
    cis_op_t shops [5] = '{OP_LSL, OP_ROL, OP_LSR, OP_ROR, OP_ASR};
    cis_op_t ctl [4] = '{OP_NOP, OP_BRK, OP_SLP, OP_WDR};
    cis_core DUT (.mclk, .sys_rst, .cmd_valid, .cmd_op, .cmd_rd, .cmd_rr, .cmd_bit, .cmd_q,
        .cmd_use_y, .cmd_io, .cmd_ready, .cmd_done, .pm_req, .pm_addr, .pm_rdata, .nvm_req,
        .nvm_addr, .nvm_wdata, .nvm_ack, .brk_pulse, .sleep_pulse, .wdr_pulse,
        .status_register, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    // Program byte is a hash of the address, so a wrong Z gives a wrong byte
    function automatic logic [7:0] pmf(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pmf
    assign pm_rdata = pmf(pm_addr);
    always #10 mclk = ~mclk;
    // Controller answers in the fourth cycle of a request, one cycle long
    always @(posedge mclk) begin
        ncnt <= nvm_req ? ncnt + 2'h1 : 2'h0;
        nvm_ack <= nvm_req && ncnt == 2'h2 && !nvm_ack;
    end
    // Expected {flags, result} of a shift; S is left alone
    function automatic logic [15:0] shf(input cis_op_t op, input logic [7:0] a,
                                        input logic [7:0] s);
        logic [7:0] r;
        logic cy;
        case (op)
            OP_LSL: {cy, r} = {a, 1'b0};
            OP_ROL: {cy, r} = {a, s[F_C]};
            OP_LSR: {r, cy} = {1'b0, a};
            OP_ROR: {r, cy} = {s[F_C], a};
            default: {r, cy} = {a[7], a};
        endcase
        s[F_C] = cy;
        s[F_Z] = (r == 8'h00);
        s[F_N] = r[7];
        s[F_V] = r[7] ^ cy;
        if (op == OP_LSL || op == OP_ROL) s[F_H] = a[3];
        return {s, r};
    endfunction : shf
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    task automatic setw(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 8'h01, d[15:8]);
    endtask : setw
    // Lat is the cycle count from take to done; zero means a stalled store
    task automatic cmd(input cis_op_t op, input logic [4:0] d, input logic [4:0] r,
                       input logic [2:0] bi, input logic [5:0] xi, input logic y, input int lat);
        int n;
        @(posedge mclk);
        cmd_op <= op;
        cmd_rd <= d;
        cmd_rr <= r;
        cmd_bit <= bi;
        cmd_q <= xi;
        cmd_io <= xi;
        cmd_use_y <= y;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        n = 1;
        #1;
        while (cmd_done !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (lat == 0) lat = (n > 1 && n < 20) ? n : 99;
        chk(16'(n), 16'(lat));
    endtask : cmd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // Run needs some 600 cycles, so this span only trips on a hang
    initial begin
        #(20 * 20000);
        err_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hfea4));
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(A_STATUS_REGISTER, STATUS_REGISTER_RST);
        rd(A_SPH, SP_RST[15:8]);
        rd(8'h80, 8'h00);
        $display("test reset done");
        sr = 8'h00;
        for (int j = 0; j < 16; j++) begin
            cmd(j < 8 ? OP_BSET : OP_BCLR, 5'h00, 5'h00, 3'(j), 6'h00, 1'b0, 1);
            sr[j % 8] = (j < 8);
            rd(A_STATUS_REGISTER, sr);
        end
        $display("test flags done");
        for (int k = 0; k < 25; k++) begin
            v = k < 10 ? (k < 5 ? 8'h80 : 8'h01) : 8'($urandom);
            sr = 8'($urandom);
            wr(8'h10, v);
            wr(A_STATUS_REGISTER, sr);
            cmd(shops[k % 5], 5'h10, 5'h00, 3'h0, 6'h00, 1'b0, 1);
            e = shf(shops[k % 5], v, sr);
            rd(8'h10, e[7:0]);
            rd(A_STATUS_REGISTER, e[15:8]);
        end
        sr = e[15:8];
        $display("test shifts done");
        v = 8'($urandom);
        w = 8'($urandom);
        wr(8'h03, v);
        wr(8'h04, w);
        wr(8'h05, ~v);
        setw(8'(R_ZL), 16'h0140);
        cmd(OP_STZI, 5'h00, 5'h03, 3'h0, 6'h00, 1'b0, 1);
        rd(8'(R_ZL), 8'h41);
        cmd(OP_STZD, 5'h00, 5'h04, 3'h0, 6'h00, 1'b0, 1);
        rd(8'(R_ZL), 8'h40);
        setw(8'(R_YL), 16'h0130);
        cmd(OP_STD, 5'h00, 5'h05, 3'h0, 6'h3f, 1'b1, 1);
        setw(A_SPL, 16'h013f);
        cmd(OP_POP, 5'h06, 5'h00, 3'h0, 6'h00, 1'b0, 2);
        rd(8'h06, w);
        setw(A_SPL, 16'h016e);
        cmd(OP_POP, 5'h07, 5'h00, 3'h0, 6'h00, 1'b0, 2);
        rd(8'h07, ~v);
        cmd(OP_PUSH, 5'h00, 5'h03, 3'h0, 6'h00, 1'b0, 1);
        cmd(OP_POP, 5'h08, 5'h00, 3'h0, 6'h00, 1'b0, 2);
        rd(8'h08, v);
        rd(A_STATUS_REGISTER, sr);
        $display("test stores done");
        setw(8'(R_ZL), 16'h1234);
        cmd(OP_LPM0, 5'h09, 5'h00, 3'h0, 6'h00, 1'b0, 3);
        rd(8'h00, pmf(16'h1234));
        cmd(OP_LPMI, 5'h09, 5'h00, 3'h0, 6'h00, 1'b0, 3);
        rd(8'h09, pmf(16'h1234));
        cmd(OP_LPM, 5'h0a, 5'h00, 3'h0, 6'h00, 1'b0, 3);
        rd(8'h0a, pmf(16'h1235));
        $display("test program load done");
        for (int k = 0; k < 6; k++) begin
            x = k == 0 ? 6'h3f : 6'($urandom);
            v = 8'($urandom);
            b = 3'($urandom);
            c = b + 3'h1;
            wr(8'h0b, v);
            cmd(OP_OUT, 5'h00, 5'h0b, 3'h0, x, 1'b0, 1);
            cmd(OP_SBI, 5'h00, 5'h00, b, x, 1'b0, 1);
            rd(A_IO_BASE + 8'(x), v | (8'h01 << b));
            cmd(OP_CBI, 5'h00, 5'h00, b, x, 1'b0, 1);
            cmd(OP_IN, 5'h0c, 5'h00, 3'h0, x, 1'b0, 1);
            v = v & ~(8'h01 << b);
            rd(8'h0c, v);
            cmd(OP_BST, 5'h00, 5'h0c, c, 6'h00, 1'b0, 1);
            sr[F_T] = v[c];
            rd(A_STATUS_REGISTER, sr);
            cmd(OP_BLD, 5'h0c, 5'h00, b, 6'h00, 1'b0, 1);
            rd(8'h0c, v | (8'(v[c]) << b));
        end
        $display("test io and bits done");
        foreach (ctl[i]) cmd(ctl[i], 5'h00, 5'h00, 3'h0, 6'h00, 1'b0, 1);
        rd(A_STATUS_REGISTER, sr);
        setw(8'(R_ZL), 16'h2000);
        // Ack comes on the third request edge, done one edge later: five in all
        cmd(OP_STZI, 5'h00, 5'h04, 3'h0, 6'h00, 1'b0, 5);
        chk(nvm_addr, 16'h2000);
        chk({8'h00, nvm_wdata}, {8'h00, w});
        rd(8'(R_ZL), 8'h01);
        rd(A_STATUS_REGISTER, sr);
        $display("test control and controller store done");
        wrap_up();
    end
endmodule : cis_core_tb
`default_nettype wire

// file: cis_pkg.sv
// Purpose: Shared constants and types for the instruction execution unit.
// Assumes: 8-bit data path, 16-bit data addresses, one clock.
// Notes: Flag positions follow the status register layout C,Z,N,V,S,H,T,I.
`default_nettype none
package cis_pkg;
    // Storage sizes
    localparam int RF_N = 32;
    localparam int IO_N = 64;
    localparam int RAM_AW = 8;
    localparam int RAM_N = 256;
    // Internal RAM window, stack and status register reset values
    localparam logic [15:0] RAM_BASE = 16'h0100;
    localparam logic [15:0] SP_RST = 16'h01ff;
    localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
    // Status register bit positions
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_H = 5;
    localparam int F_T = 6;
    // R0 and the pointer registers inside the register file
    localparam logic [4:0] R_ZERO = 5'h00;
    localparam logic [4:0] R_YL = 5'h1c;
    localparam logic [4:0] R_YH = 5'h1d;
    localparam logic [4:0] R_ZL = 5'h1e;
    localparam logic [4:0] R_ZH = 5'h1f;
    // Register port map
    localparam logic [7:0] A_IO_BASE = 8'h20;
    localparam logic [7:0] A_IO_END = 8'h5f;
    localparam logic [7:0] A_STATUS_REGISTER = 8'h60;
    localparam logic [7:0] A_SPL = 8'h61;
    localparam logic [7:0] A_SPH = 8'h62;
    localparam logic [7:0] A_STAT = 8'h63;
    // Cycle counts of the multi-cycle instructions
    localparam logic [1:0] CYC_POP = 2'h2;
    localparam logic [1:0] CYC_LPM = 2'h3;
    // Operations accepted on the command port
    typedef enum logic [4:0] {
        OP_NOP, OP_BRK, OP_SLP, OP_WDR,
        OP_STD, OP_STZI, OP_STZD,
        OP_LPM0, OP_LPM, OP_LPMI,
        OP_IN, OP_OUT, OP_PUSH, OP_POP,
        OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP,
        OP_SBI, OP_CBI, OP_BST, OP_BLD, OP_BSET, OP_BCLR
    } cis_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_MULTI, ST_NVM} cis_state_t;
endpackage : cis_pkg
`default_nettype wire
